/* File: core/ctrl_channel_regs.sv */
// control-channel I2C control, scratch and self-test registers
// Overview of operation
// - Sequence error event from forward channel sets a read-only sticky flag.
// - Setting the clear bit clears the sequence error flag.
// - Two-bit field adds SDA output delay, 350 ns plus 50 ns per step.
// - With remote block set, writes from across the channel to local regs drop.
// - Blocking never stops remote accesses forwarded to local-side slaves.
// - Watchdog times out near 1 s normally, near 50 us when sped up.
// - SDA high and idle for the timeout marks the bus free; disable bit off.
// - SDA low and idle for the timeout triggers nine SCL recovery pulses.
// - Self-test from pin when source bit is 1, else from enable bit.
`timescale 1ns/1ps
module ctrl_channel_regs
  import ctrl_regs_pkg::*;
#(
  parameter longint WD_SLOW_COUNT = WD_SLOW_CYC
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // register access from the I2C slave logic
  input  wire reg_wr_s    regWr,
  input  wire logic [7:0] rdAddr,
  output logic [7:0]      rdData,
  // forward-channel event and forwarding
  input  wire logic       seqErrEvent,
  input  wire logic       fwdToSlave,
  output logic            fwdAllowed,
  // I2C pins (oe low = driving)
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sclOut,
  output logic            sclOe,
  input  wire logic       sdaDrive,
  output logic            sdaOut,
  output logic            sdaOe,
  output logic            busFree,
  // self-test
  input  wire logic       selfTestPin,
  output logic            selfTestEn,
  output logic [1:0]      selfTestClkSel
);
  typedef enum logic [1:0] {WD_IDLE, WD_RECOVER} wd_state_e;

  logic [7:0]  i2cCtrlReg;
  logic [7:0]  scratchReg;
  logic [7:0]  selfTestReg;
  logic        sclSync;
  logic        sclChg;
  logic        sdaSync;
  logic        sdaChg;
  logic        stPinSync;
  logic [39:0] wdCntReg;
  logic [8:0]  halfCntReg;
  logic [4:0]  edgeCntReg;
  logic [7:0]  dlyCntReg;
  logic        sdaDlyReg;
  logic        sclDrvReg;
  wd_state_e   wdStateReg;

  // ==========================================================
  // synchronisers
  sync_edge u_scl (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .asyncIn (sclIn),
    .level   (sclSync),
    .changed (sclChg)
  );

  sync_edge u_sda (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .asyncIn (sdaIn),
    .level   (sdaSync),
    .changed (sdaChg)
  );

  sync_edge u_st (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .asyncIn (selfTestPin),
    .level   (stPinSync),
    .changed ()
  );

  // ==========================================================
  // write decode
  wire wrAllowed  = regWr.valid && !(regWr.remote
                    && i2cCtrlReg[REMOTE_BLK_BIT]);
  wire wrI2cCtrl  = wrAllowed && (regWr.addr == I2C_CTRL_ADDR);
  wire wrScratch  = wrAllowed && (regWr.addr == SCRATCH_ADDR);
  wire wrSelfTest = wrAllowed && (regWr.addr == SELF_TEST_ADDR);
  // clear bit is a level: flag cleared each cycle it stays set, except a cycle with an event
  wire seqClr     = i2cCtrlReg[SEQ_CLR_BIT];

  // forwarding to local-side slaves ignores the block bit
  assign fwdAllowed = fwdToSlave;

  // register storage
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      i2cCtrlReg  <= I2C_CTRL_RST;
      scratchReg  <= SCRATCH_RST;
      selfTestReg <= SELF_TEST_RST;
    end else begin
      if (wrI2cCtrl) begin
        i2cCtrlReg[6:0] <= {regWr.data[6], 1'b0, regWr.data[4:0]};
      end
      if (seqErrEvent) begin
        i2cCtrlReg[SEQ_ERR_BIT] <= 1'b1;  // set wins
      end else if (seqClr) begin
        i2cCtrlReg[SEQ_ERR_BIT] <= 1'b0;
      end
      if (wrScratch) begin
        scratchReg <= regWr.data;
      end
      if (wrSelfTest) begin
        selfTestReg <= {4'h0, regWr.data[3:0]};
      end
    end
  end

  // read mux, unmapped reads zero
  assign rdData = (rdAddr == I2C_CTRL_ADDR)  ? i2cCtrlReg  :
                  (rdAddr == SCRATCH_ADDR)   ? scratchReg  :
                  (rdAddr == SELF_TEST_ADDR) ? selfTestReg : 8'h00;

  // ==========================================================
  // self-test source
  assign selfTestEn = selfTestReg[ST_PIN_BIT] ? stPinSync
                      : selfTestReg[ST_EN_BIT];
  assign selfTestClkSel = selfTestReg[ST_CLK_LSB +: 2];

  // ==========================================================
  // SDA output delay after SCL falling edge
  wire [7:0] dlyTarget = 8'(SDA_BASE_CYC)
    + 8'(SDA_STEP_CYC) * {6'h00, i2cCtrlReg[SDA_DLY_LSB +: 2]};
  wire sclFall = sclChg && sclSync;

  // while scl is high sda follows at once; low-phase changes wait
  // delay counter restarts on every synced scl fall
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dlyCntReg <= 8'h00;
      sdaDlyReg <= 1'b1;
    end else if (sclFall) begin
      dlyCntReg <= 8'h01;
    end else if (dlyCntReg != 8'h00) begin
      dlyCntReg <= (dlyCntReg >= dlyTarget) ? 8'h00 : dlyCntReg + 8'h01;
      if (dlyCntReg >= dlyTarget) begin
        sdaDlyReg <= sdaDrive;
      end
    end else if (!sclSync) begin
      sdaDlyReg <= sdaDlyReg;
    end else begin
      sdaDlyReg <= sdaDrive;
    end
  end

  // open drain: only ever pulls sda low
  assign sdaOut = 1'b0;
  assign sdaOe  = sdaDlyReg;

  // ==========================================================
  // bus watchdog: idle timer, free flag and recovery clocking
  wire [39:0] wdLimit = i2cCtrlReg[WD_FAST_BIT] ? 40'(WD_FAST_CYC)
                        : 40'(WD_SLOW_COUNT);
  wire busAct  = sclChg || sdaChg;
  wire wdOn    = !i2cCtrlReg[WD_DIS_BIT];
  wire wdFire  = wdOn && (wdCntReg >= wdLimit);

  // idle count, then free flag or recovery clocking
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wdCntReg   <= 40'h0000000000;
      busFree    <= 1'b0;
      wdStateReg <= WD_IDLE;
      halfCntReg <= 9'h000;
      edgeCntReg <= 5'h00;
      sclDrvReg  <= 1'b0;
    end else begin
      case (wdStateReg)
        WD_IDLE: begin
          sclDrvReg <= 1'b0;
          if (busAct || !wdOn) begin
            wdCntReg <= 40'h0000000000;
            busFree  <= 1'b0;
          end else if (wdFire) begin
            wdCntReg <= 40'h0000000000;
            if (sdaSync) begin
              busFree <= 1'b1;
            end else begin
              wdStateReg <= WD_RECOVER;
              edgeCntReg <= 5'h00;
              halfCntReg <= 9'h000;
            end
          end else begin
            wdCntReg <= wdCntReg + 40'h0000000001;
          end
        end
        WD_RECOVER: begin
          // hung bus: count half periods, stop after the ninth pulse
          if (halfCntReg == 9'(SCL_HALF_CYC - 1)) begin
            halfCntReg <= 9'h000;
            sclDrvReg  <= ~sclDrvReg;
            edgeCntReg <= edgeCntReg + 5'h01;
            if (edgeCntReg == 5'(2 * RECOV_PULSES - 1)) begin
              wdStateReg <= WD_IDLE;  // nine pulses done
              sclDrvReg  <= 1'b0;
            end
          end else begin
            halfCntReg <= halfCntReg + 9'h001;
          end
        end
        default: wdStateReg <= WD_IDLE;
      endcase
    end
  end

  // recovery clock only ever pulls scl low
  assign sclOut = 1'b0;
  assign sclOe  = !sclDrvReg;  // low pulls SCL low
endmodule // ctrl_channel_regs

/* File: core/ctrl_regs_pkg.sv */
// package: register map, field positions and timing counts
package ctrl_regs_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] I2C_CTRL_ADDR    = 8'h22;
  localparam logic [7:0] SCRATCH_ADDR     = 8'h23;
  localparam logic [7:0] SELF_TEST_ADDR   = 8'h24;

  // ==========================================================
  // control_channel_i2c_control fields
  localparam int SEQ_ERR_BIT     = 7;
  localparam int SEQ_CLR_BIT     = 6;
  localparam int SDA_DLY_LSB     = 3;
  localparam int REMOTE_BLK_BIT  = 2;
  localparam int WD_FAST_BIT     = 1;
  localparam int WD_DIS_BIT      = 0;
  localparam logic [7:0] I2C_CTRL_RST    = 8'h00;

  // ==========================================================
  // self_test_control fields
  localparam int ST_PIN_BIT      = 3;
  localparam int ST_CLK_LSB      = 1;
  localparam int ST_EN_BIT       = 0;
  localparam logic [7:0] SELF_TEST_RST   = 8'h08;
  localparam logic [7:0] SCRATCH_RST     = 8'h00;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_PS   = 4000;
  localparam int SDA_BASE_NS     = 350;
  localparam int SDA_STEP_NS     = 50;
  localparam int SDA_BASE_CYC    = (SDA_BASE_NS * 1000) / CLK_PERIOD_PS;
  localparam int SDA_STEP_CYC    = (SDA_STEP_NS * 1000) / CLK_PERIOD_PS;
  localparam int WD_FAST_US      = 50;
  localparam int WD_SLOW_S       = 1;
  localparam int WD_FAST_CYC     = (WD_FAST_US * 1000000) / CLK_PERIOD_PS;
  localparam longint WD_SLOW_CYC =
    (longint'(WD_SLOW_S) * 64'hE8D4A51000) / CLK_PERIOD_PS;
  localparam int RECOV_PULSES    = 9;
  localparam int SCL_HALF_CYC    = 313;  // ~400 kHz recovery clock

  // ==========================================================
  // register write request from the I2C slave logic
  typedef struct packed {
    logic       valid;
    logic       remote;  // arrived across the control channel
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_s;

endpackage

/* File: core/sync_edge.sv */
// three-stage synchroniser with agreement-based change detection
`timescale 1ns/1ps
module sync_edge (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // pin side
  input  wire logic asyncIn,
  // synchronised side
  output logic      level,
  output logic      changed
);
  logic stage1Reg;
  logic stage2Reg;
  logic stage3Reg;

  // stage1 feeds stage2 only
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stage1Reg <= 1'b1;
      stage2Reg <= 1'b1;
      stage3Reg <= 1'b1;
      level     <= 1'b1;
    end else begin
      stage1Reg <= asyncIn;
      stage2Reg <= stage1Reg;
      stage3Reg <= stage2Reg;
      if (stage2Reg == stage3Reg) begin
        level <= stage3Reg;
      end
    end
  end

  assign changed = (stage2Reg == stage3Reg) && (stage3Reg != level);
endmodule // sync_edge

/* File: verification/ctrl_channel_regs_properties.sv */
// checker: port properties of the register bank
`timescale 1ns/1ps
module ctrl_channel_regs_checker
  import ctrl_regs_pkg::*;
(
  // watched ports
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire reg_wr_s    regWr,
  input wire logic [7:0] rdAddr,
  input wire logic [7:0] rdData,
  input wire logic       seqErrEvent,
  input wire logic       fwdToSlave,
  input wire logic       fwdAllowed,
  input wire logic       sclOe,
  input wire logic       busFree,
  input wire logic       selfTestEn,
  input wire logic [1:0] selfTestClkSel
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // control register shown on the read port
  wire logic ctl = rdAddr == I2C_CTRL_ADDR;
  wire logic st = rdAddr == SELF_TEST_ADDR;
  sequence s_blkWr;
    ctl && rdData[REMOTE_BLK_BIT] && regWr.valid && regWr.remote;
  endsequence
  property p_seqSet;
    seqErrEvent ##1 ctl |-> rdData[SEQ_ERR_BIT];
  endproperty
  a_seqSet: assert property (p_seqSet) else $error("flag not set");
  property p_seqClr;
    ctl && rdData[SEQ_CLR_BIT] && !seqErrEvent ##1 ctl |-> !rdData[7];
  endproperty
  a_seqClr: assert property (p_seqClr) else $error("flag held");
  property p_blk;
    s_blkWr ##1 $stable(rdAddr) |-> rdData[6:0] == $past(rdData[6:0]);
  endproperty
  a_blk: assert property (p_blk) else $error("remote write taken");
  property p_fwd; fwdAllowed == fwdToSlave; endproperty
  a_fwd: assert property (p_fwd) else $error("forward blocked");
  property p_stReg; st && !rdData[ST_PIN_BIT] |-> selfTestEn == rdData[0];
  endproperty
  a_stReg: assert property (p_stReg) else $error("self-test source");
  property p_clkSel; st |-> selfTestClkSel == rdData[2:1]; endproperty
  a_clkSel: assert property (p_clkSel) else $error("clock select");
  property p_wdOff; ctl && rdData[WD_DIS_BIT] && !busFree |=> !busFree;
  endproperty
  a_wdOff: assert property (p_wdOff) else $error("watchdog not off");
  property p_recov; $fell(sclOe) |=> !sclOe [*8]; endproperty
  a_recov: assert property (p_recov) else $error("short scl pulse");
endmodule // ctrl_channel_regs_checker
bind ctrl_channel_regs ctrl_channel_regs_checker u_checker (.*);

/* File: verification/i2c_far_end.sv */
// far-end I2C master model with pulled-up lines
`timescale 1ns/1ps
module i2c_far_end (
  // bench control
  input wire logic run,
  input wire logic holdLow,
  // device pin enables, low = pulling low
  input wire logic sclOe,
  input wire logic sdaOe,
  // wire levels
  output logic     scl,
  output logic     sda
);
  logic sclQ = 1'b1;
  // frame clock, 80 ns period, idle high between frames
  initial begin
    #1.3;
    forever #40 sclQ = run ? ~sclQ : 1'b1;
  end
  // open drain: any low wins, pull-up otherwise
  assign scl = sclQ & sclOe;
  assign sda = !holdLow & sdaOe;
endmodule // i2c_far_end

/* File: verification/tb_ctrl_channel_regs.sv */
// self-checking bench for the control-channel register bank
`timescale 1ns/1ps
module tb_ctrl_channel_regs;
  import ctrl_regs_pkg::*;
  // ==========
  // stimulus and observed signals
  logic sys_clk = 0, sys_rst = 1, seqErrEvent = 0, fwdToSlave = 0;
  logic sdaDrive = 1, selfTestPin = 1, run = 0, holdLow = 0;
  logic fwdAllowed, sclOe, sdaOe, busFree, selfTestEn, scl, sda, pv;
  logic sclOut, sdaOut;
  logic [7:0] rdAddr = I2C_CTRL_ADDR, rdData;
  logic [1:0] selfTestClkSel;
  reg_wr_s regWr = '0;
  int n_errors = 0, n_compared = 0, seed = 80133, n, m, k0, k1;
  always #2 sys_clk = ~sys_clk;
  ctrl_channel_regs #(.WD_SLOW_COUNT(20000)) u_ctrl_channel_regs (.*,
    .sclIn(scl), .sdaIn(sda));
  i2c_far_end u_i2c_far_end (.*);
  // ==========
  // expectation, compare and bus tasks
  function automatic int dlyCyc(int c);
    return SDA_BASE_CYC + SDA_STEP_CYC * c;
  endfunction
  task automatic chk(string w, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic test_done();
    if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, d, logic r = 0);
    @(negedge sys_clk) regWr = '{1'b1, r, a, d};
    @(negedge sys_clk) regWr.valid = 0;
  endtask
  task automatic rd(logic [7:0] a, e, string w);
    @(negedge sys_clk) rdAddr = a;
    #1 chk(w, e, rdData);
  endtask
  task automatic waitFor(ref logic s, input logic v, int lim);
    for (n = 0; s !== v; n++) begin
      if (n == lim) chk("wait", v, s);
      if (n == lim) test_done();
      @(negedge sys_clk);
    end
  endtask
  task automatic frame();
    run = 1;
    repeat (30) @(negedge sys_clk);
    run = 0;
  endtask
  task automatic dly(logic [1:0] c, logic v, output int k);
    sdaDrive = !v;
    wr(I2C_CTRL_ADDR, {3'b0, c, 3'b0});
    run = 1;
    waitFor(scl, 0, 40);
    run = 0;
    repeat (4) @(negedge sys_clk);
    sdaDrive = v;
    waitFor(sdaOe, v, 300);
    k = n;
  endtask
  // ==========
  // main sequence
  initial begin
    repeat (16) @(negedge sys_clk);
    sys_rst = 0;
    rd(I2C_CTRL_ADDR, I2C_CTRL_RST, "ctl");
    rd(SCRATCH_ADDR, SCRATCH_RST, "scr");
    rd(SELF_TEST_ADDR, SELF_TEST_RST, "st");
    rd(8'h25, 8'h00, "unmapped");
    chk("stEn", 1, selfTestEn);
    repeat (6) begin
      m = $random(seed);
      selfTestPin = m[16];
      wr(SCRATCH_ADDR, m[7:0]);
      rd(SCRATCH_ADDR, m[7:0], "scr");
      wr(SELF_TEST_ADDR, m[15:8]);
      rd(SELF_TEST_ADDR, m[15:8] & 8'h0F, "st");
      chk("clkSel", m[10:9], selfTestClkSel);
      chk("stEn", m[11] ? m[16] : m[8], selfTestEn);
    end
    rdAddr = I2C_CTRL_ADDR;
    seqErrEvent = 1;
    @(negedge sys_clk) seqErrEvent = 0;
    rd(I2C_CTRL_ADDR, 8'h80, "seqErr");
    wr(I2C_CTRL_ADDR, 8'hC0);
    rd(I2C_CTRL_ADDR, 8'h40, "seqClr");
    wr(I2C_CTRL_ADDR, 8'h04);
    wr(I2C_CTRL_ADDR, 8'h00, 1);
    rd(I2C_CTRL_ADDR, 8'h04, "blkCtl");
    wr(SCRATCH_ADDR, ~m[7:0], 1);
    fwdToSlave = 1;
    rd(SCRATCH_ADDR, m[7:0], "blkScr");
    chk("fwd", 1, fwdAllowed);
    wr(I2C_CTRL_ADDR, 8'h00);
    wr(SCRATCH_ADDR, ~m[7:0], 1);
    rd(SCRATCH_ADDR, ~m[7:0], "remote");
    dly(2'd0, 0, k0);
    dly(2'd3, 1, k1);
    chk("sdaDly", dlyCyc(3) - dlyCyc(0), k1 - k0);
    wr(I2C_CTRL_ADDR, 8'h03);
    rd(I2C_CTRL_ADDR, 8'h03, "wdCtl");
    frame();
    repeat (13000) @(negedge sys_clk);
    chk("wdOff", 0, busFree);
    wr(I2C_CTRL_ADDR, 8'h02);
    frame();
    waitFor(busFree, 1, 13000);
    chk("wdFast", 1, n > 12400 && n < 12600);
    holdLow = 1;
    frame();
    m = 0;
    repeat (19000) begin
      pv = sclOe;
      @(negedge sys_clk);
      m += pv && !sclOe;
    end
    chk("recov", 9, m);
    holdLow = 0;
    wr(I2C_CTRL_ADDR, 8'h00);
    frame();
    waitFor(busFree, 1, 21000);
    chk("wdSlow", 1, n > 19900 && n < 20100);
    chk("pinLow", 0, {sclOut, sdaOut});
    test_done();
  end
endmodule // tb_ctrl_channel_regs
